// File: smspi_pkg.sv
package smspi_pkg;

	localparam int unsigned ADDR_W          = 17;
	localparam int unsigned ADDR_BYTES      = 3;
	localparam int unsigned ADDR_SKIP_BITS  = 7;
	localparam int unsigned BYTE_W          = 8;
	localparam int unsigned STATUS_W        = 8;
	localparam logic [3:0]  BITS_PER_BYTE   = 4'h8;
	localparam logic [1:0]  LAST_ADDR_BYTE  = 2'h2;
	localparam logic [7:0]  STATUS_RST      = 8'h40;
	localparam logic [7:0]  STATUS_WR_MASK  = 8'h8c;
	localparam int unsigned STATUS_WEL_BIT  = 1;
	localparam logic [2:0]  CSN_SYNC_RST    = 3'h7;
	localparam logic [2:0]  PIN_SYNC_RST    = 3'h0;
	localparam logic [ADDR_W-1:0] ADDR_RST  = 17'h00000;
	localparam logic [7:0]  BYTE_RST        = 8'h00;

	typedef enum logic [7:0] {
		SMSPI_OP_SET_WRITE_LATCH   = 8'h06,
		SMSPI_OP_CLEAR_WRITE_LATCH = 8'h04,
		SMSPI_OP_STATUS_READ       = 8'h05,
		SMSPI_OP_STATUS_WRITE      = 8'h01,
		SMSPI_OP_MEM_READ          = 8'h03,
		SMSPI_OP_FAST_READ         = 8'h0b,
		SMSPI_OP_MEM_WRITE         = 8'h02,
		SMSPI_OP_SLEEP             = 8'hb9,
		SMSPI_OP_IDENTITY_READ     = 8'h9f,
		SMSPI_OP_SERIAL_NUM_READ   = 8'hc3
	} smspi_op_t;

	typedef enum logic [3:0] {
		SMSPI_CMD_NONE  = 4'h0,
		SMSPI_CMD_SETWL = 4'h1,
		SMSPI_CMD_CLRWL = 4'h2,
		SMSPI_CMD_STRD  = 4'h3,
		SMSPI_CMD_STWR  = 4'h4,
		SMSPI_CMD_READ  = 4'h5,
		SMSPI_CMD_FREAD = 4'h6,
		SMSPI_CMD_WRITE = 4'h7,
		SMSPI_CMD_SLEEP = 4'h8,
		SMSPI_CMD_IDRD  = 4'h9,
		SMSPI_CMD_SNRD  = 4'ha
	} smspi_cmd_t;

	typedef enum logic [4:0] {
		SMSPI_ST_IDLE   = 5'b00001,
		SMSPI_ST_OPCODE = 5'b00010,
		SMSPI_ST_ADDR   = 5'b00100,
		SMSPI_ST_DATA   = 5'b01000,
		SMSPI_ST_IGNORE = 5'b10000
	} smspi_state_t;

	function automatic smspi_cmd_t smspi_decode(input logic [7:0] op);
		case (op)
			SMSPI_OP_SET_WRITE_LATCH:   smspi_decode = SMSPI_CMD_SETWL;
			SMSPI_OP_CLEAR_WRITE_LATCH: smspi_decode = SMSPI_CMD_CLRWL;
			SMSPI_OP_STATUS_READ:       smspi_decode = SMSPI_CMD_STRD;
			SMSPI_OP_STATUS_WRITE:      smspi_decode = SMSPI_CMD_STWR;
			SMSPI_OP_MEM_READ:          smspi_decode = SMSPI_CMD_READ;
			SMSPI_OP_FAST_READ:         smspi_decode = SMSPI_CMD_FREAD;
			SMSPI_OP_MEM_WRITE:         smspi_decode = SMSPI_CMD_WRITE;
			SMSPI_OP_SLEEP:             smspi_decode = SMSPI_CMD_SLEEP;
			SMSPI_OP_IDENTITY_READ:     smspi_decode = SMSPI_CMD_IDRD;
			SMSPI_OP_SERIAL_NUM_READ:   smspi_decode = SMSPI_CMD_SNRD;
			default:                    smspi_decode = SMSPI_CMD_NONE;
		endcase
	endfunction : smspi_decode

	function automatic logic smspi_has_addr(input smspi_cmd_t c);
		smspi_has_addr = (c == SMSPI_CMD_READ) || (c == SMSPI_CMD_FREAD)
			|| (c == SMSPI_CMD_WRITE);
	endfunction : smspi_has_addr

endpackage : smspi_pkg

// File: smspi_sync.sv
`timescale 1ns/1ns
module smspi_sync
	import smspi_pkg::*;
#(
	parameter int unsigned N              = 3,
	parameter logic [N-1:0] RST_VAL       = '0
)(
	// Clock and reset.
	input  wire logic         i_clk,
	input  wire logic         i_rst,
	// Asynchronous levels in and synchronised levels out.
	input  wire logic [N-1:0] i_async,
	output logic      [N-1:0] o_sync
);

	logic [N-1:0] meta_q;
	logic [N-1:0] sync_q;

	// Two flip-flops per pin; the first one feeds only the second.
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			meta_q <= RST_VAL;
			sync_q <= RST_VAL;
		end
		else
		begin
			meta_q <= i_async;
			sync_q <= meta_q;
		end
	end

	assign o_sync = sync_q;

endmodule : smspi_sync

// File: smspi_shift.sv
`timescale 1ns/1ns
module smspi_shift
	import smspi_pkg::*;
(
	// Clock and reset.
	input  wire logic       i_clk,
	input  wire logic       i_rst,
	// Control.
	input  wire logic       i_clear,
	input  wire logic       i_rise,
	input  wire logic       i_bit,
	// Assembled byte.
	output logic            o_byte_done,
	output logic [7:0]      o_byte
);

	logic [3:0] cnt_q;
	logic [7:0] sh_q;
	logic [7:0] sh_d;

	assign sh_d = {sh_q[6:0], i_bit};

	// Bits enter MSB first and a byte completes on every eighth rise.
	always_ff @(posedge i_clk)
	begin
		if (i_rst || i_clear)
		begin
			cnt_q       <= 4'h0;
			sh_q        <= BYTE_RST;
			o_byte_done <= 1'b0;
			o_byte      <= BYTE_RST;
		end
		else
		begin
			o_byte_done <= 1'b0;
			if (i_rise)
			begin
				sh_q <= sh_d;
				if (cnt_q == BITS_PER_BYTE - 4'h1)
				begin
					cnt_q       <= 4'h0;
					o_byte_done <= 1'b1;
					o_byte      <= sh_d;
				end
				else
				begin
					cnt_q <= cnt_q + 4'h1;
				end
			end
		end
	end

endmodule : smspi_shift

// File: smspi_front.sv
`timescale 1ns/1ns
module smspi_front
	import smspi_pkg::*;
(
	// Clock and reset.
	input  wire logic              i_clk,
	input  wire logic              i_rst,
	// Serial pins.
	input  wire logic              i_csn,
	input  wire logic              i_sck,
	input  wire logic              i_si,
	input  wire logic              i_holdn,
	output logic                   o_so,
	output logic                   o_so_oen,
	// Decoded command.
	output logic                   o_active,
	output logic                   o_mode3,
	output logic                   o_cmd_valid,
	output logic [3:0]             o_cmd,
	output logic                   o_bad_op,
	output logic                   o_addr_valid,
	output logic [ADDR_W-1:0]      o_addr,
	output logic                   o_data_valid,
	output logic [7:0]             o_data,
	output logic                   o_write_strobe,
	output logic                   o_write_latch,
	output logic [STATUS_W-1:0]    o_status
);

	logic [2:0]   pins_s;
	logic         csn_s;
	logic         sck_s;
	logic         holdn_s;
	logic         si_s;
	logic         sck_prev_q;
	logic         csn_prev_q;
	logic         sel_fall;
	logic         sel_rise;
	logic         rise;
	logic         fall;
	logic         armed_q;
	logic         hold_ok;
	smspi_state_t state_q;
	smspi_cmd_t   cmd_q;
	smspi_cmd_t   dec;
	logic [1:0]   abyte_q;
	logic [ADDR_W-1:0] addr_q;
	logic [7:0]   status_q;
	logic         wel_q;
	logic         wel_clr_q;
	logic         byte_done;
	logic [7:0]   byte_in;
	logic [7:0]   tx_q;
	logic         tx_en_q;
	logic         bad_q;

	smspi_sync #(
		.N       (3),
		.RST_VAL (CSN_SYNC_RST)
	) u_sync_ctl (
		.i_clk   (i_clk),
		.i_rst   (i_rst),
		.i_async ({i_csn, i_holdn, i_sck}),
		.o_sync  (pins_s)
	);

	smspi_sync #(
		.N       (1),
		.RST_VAL (PIN_SYNC_RST[0])
	) u_sync_dat (
		.i_clk   (i_clk),
		.i_rst   (i_rst),
		.i_async (i_si),
		.o_sync  (si_s)
	);

	assign csn_s   = pins_s[2];
	assign holdn_s = pins_s[1];
	assign sck_s   = pins_s[0];

	// Hold low freezes clock and select activity.
	assign hold_ok  = holdn_s;
	assign sel_fall = hold_ok && csn_prev_q && !csn_s;
	assign sel_rise = hold_ok && !csn_prev_q && csn_s;
	// Mode 3 counts rises only after the clock has fallen once.
	assign rise = hold_ok && !csn_s && !sck_prev_q && sck_s && armed_q;
	assign fall = hold_ok && !csn_s && sck_prev_q && !sck_s;
	assign dec  = smspi_decode(byte_in);

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			sck_prev_q <= 1'b0;
			csn_prev_q <= 1'b1;
		end
		else if (hold_ok)
		begin
			sck_prev_q <= sck_s;
			csn_prev_q <= csn_s;
		end
	end

	// Mode chosen from the clock level at select.
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			o_mode3 <= 1'b0;
			armed_q <= 1'b0;
		end
		else if (sel_fall)
		begin
			o_mode3 <= sck_s;
			armed_q <= !sck_s;
		end
		else if (fall)
		begin
			armed_q <= 1'b1;
		end
	end

	smspi_shift u_shift (
		.i_clk       (i_clk),
		.i_rst       (i_rst),
		.i_clear     (sel_fall || csn_s),
		.i_rise      (rise && state_q != SMSPI_ST_IGNORE),
		.i_bit       (si_s),
		.o_byte_done (byte_done),
		.o_byte      (byte_in)
	);

	// Byte sequencing inside one select period.
	always_ff @(posedge i_clk)
	begin
		if (i_rst || csn_s)
		begin
			state_q <= SMSPI_ST_IDLE;
		end
		else if (sel_fall)
		begin
			state_q <= SMSPI_ST_OPCODE;
		end
		else if (byte_done)
		begin
			unique case (state_q)
				SMSPI_ST_OPCODE:
				begin
					if (dec == SMSPI_CMD_NONE)
						state_q <= SMSPI_ST_IGNORE;
					else if (smspi_has_addr(dec))
						state_q <= SMSPI_ST_ADDR;
					else
						state_q <= SMSPI_ST_DATA;
				end
				SMSPI_ST_ADDR:
				begin
					if (abyte_q == LAST_ADDR_BYTE)
						state_q <= SMSPI_ST_DATA;
				end
				SMSPI_ST_IDLE, SMSPI_ST_DATA, SMSPI_ST_IGNORE:
				begin
					state_q <= state_q;
				end
			endcase
		end
	end

	// Opcode and address capture.
	always_ff @(posedge i_clk)
	begin
		if (i_rst || sel_fall)
		begin
			cmd_q   <= SMSPI_CMD_NONE;
			abyte_q <= 2'h0;
			addr_q  <= ADDR_RST;
			bad_q   <= 1'b0;
		end
		else if (byte_done && state_q == SMSPI_ST_OPCODE)
		begin
			cmd_q <= dec;
			bad_q <= (dec == SMSPI_CMD_NONE);
		end
		else if (byte_done && state_q == SMSPI_ST_ADDR)
		begin
			abyte_q <= abyte_q + 2'h1;
			// Upper 7 of 24 bits fall off the top of the register.
			addr_q  <= {addr_q[ADDR_W-9:0], byte_in};
		end
		else if (byte_done && state_q == SMSPI_ST_DATA)
		begin
			addr_q <= addr_q + 17'h00001;
		end
	end

	// Command outputs are one-cycle pulses or held levels.
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			o_active       <= 1'b0;
			o_cmd_valid    <= 1'b0;
			o_cmd          <= SMSPI_CMD_NONE;
			o_bad_op       <= 1'b0;
			o_addr_valid   <= 1'b0;
			o_addr         <= ADDR_RST;
			o_data_valid   <= 1'b0;
			o_data         <= BYTE_RST;
			o_write_strobe <= 1'b0;
		end
		else
		begin
			o_active     <= !csn_s;
			o_cmd_valid  <= byte_done && state_q == SMSPI_ST_OPCODE && dec != SMSPI_CMD_NONE;
			o_bad_op     <= bad_q;
			o_addr_valid <= byte_done && state_q == SMSPI_ST_ADDR && abyte_q == LAST_ADDR_BYTE;
			o_data_valid <= byte_done && state_q == SMSPI_ST_DATA;
			// A written byte is committed as soon as it has shifted in.
			o_write_strobe <= byte_done && state_q == SMSPI_ST_DATA
				&& cmd_q == SMSPI_CMD_WRITE && wel_q;
			if (byte_done && state_q == SMSPI_ST_OPCODE)
				o_cmd <= dec;
			if (byte_done)
				o_data <= byte_in;
			// The third address byte is folded in so the address stands with its pulse.
			o_addr <= (byte_done && state_q == SMSPI_ST_ADDR)
				? {addr_q[ADDR_W-9:0], byte_in} : addr_q;
		end
	end

	// Write latch and status register.
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			wel_q     <= 1'b0;
			wel_clr_q <= 1'b0;
			status_q  <= STATUS_RST;
		end
		else
		begin
			// A set or a new clear request in the same cycle wins over the pending clear.
			if (sel_rise && wel_clr_q)
			begin
				wel_q     <= 1'b0;
				wel_clr_q <= 1'b0;
			end
			if (byte_done && state_q == SMSPI_ST_OPCODE && dec == SMSPI_CMD_SETWL)
				wel_q <= 1'b1;
			if (byte_done && state_q == SMSPI_ST_OPCODE
				&& (dec == SMSPI_CMD_CLRWL || dec == SMSPI_CMD_STWR
				|| dec == SMSPI_CMD_WRITE))
				wel_clr_q <= 1'b1;
			if (byte_done && state_q == SMSPI_ST_DATA && cmd_q == SMSPI_CMD_STWR && wel_q)
				status_q <= (status_q & ~STATUS_WR_MASK) | (byte_in & STATUS_WR_MASK);
		end
	end

	assign o_write_latch = wel_q;
	assign o_status      = {status_q[7:2], wel_q, 1'b0};

	// Serial output: status bytes shift out MSB first on falling edges.
	always_ff @(posedge i_clk)
	begin
		// Hold only pauses the shifter; the output enable releases the pin meanwhile.
		if (i_rst || csn_s)
		begin
			tx_en_q <= 1'b0;
			tx_q    <= BYTE_RST;
		end
		else if (byte_done && state_q == SMSPI_ST_OPCODE && dec == SMSPI_CMD_STRD)
		begin
			tx_en_q <= 1'b1;
			tx_q    <= {status_q[7:2], wel_q, 1'b0};
		end
		else if (fall && tx_en_q)
		begin
			tx_q <= {tx_q[6:0], tx_q[7]};
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			o_so     <= 1'b0;
			o_so_oen <= 1'b1;
		end
		else
		begin
			// Released when deselected, held, or after an unknown opcode.
			o_so_oen <= csn_s || !holdn_s || bad_q || !tx_en_q;
			if (fall && tx_en_q)
				o_so <= tx_q[7];
		end
	end

	sequence sel_seq;
		$fell(csn_s) && holdn_s;
	endsequence

	bad_release_a: assert property (@(posedge i_clk) disable iff (i_rst)
		o_bad_op |-> o_so_oen)
		else $error("Output driven after unknown opcode.");

	desel_release_a: assert property (@(posedge i_clk) disable iff (i_rst)
		csn_s |=> o_so_oen && !o_active)
		else $error("Output driven while deselected.");

	mode_pick_a: assert property (@(posedge i_clk) disable iff (i_rst)
		sel_seq |=> o_mode3 == $past(sck_s))
		else $error("Mode not taken from clock level.");

	hold_release_a: assert property (@(posedge i_clk) disable iff (i_rst)
		!holdn_s |=> o_so_oen)
		else $error("Output driven during hold.");

	opcode_state_a: assert property (@(posedge i_clk) disable iff (i_rst)
		sel_seq |=> state_q == SMSPI_ST_OPCODE)
		else $error("Opcode phase not entered on select.");

	ignore_stay_a: assert property (@(posedge i_clk) disable iff (i_rst)
		state_q == SMSPI_ST_IGNORE && !csn_s |=> state_q == SMSPI_ST_IGNORE || csn_s)
		else $error("Left ignore state without deselect.");

	addr_bytes_a: assert property (@(posedge i_clk) disable iff (i_rst)
		o_addr_valid |-> $past(abyte_q) == LAST_ADDR_BYTE)
		else $error("Address not completed after three bytes.");

	write_latch_a: assert property (@(posedge i_clk) disable iff (i_rst)
		o_write_strobe |-> $past(wel_q) && cmd_q == SMSPI_CMD_WRITE)
		else $error("Write committed without latch.");

	status_fixed_a: assert property (@(posedge i_clk) disable iff (i_rst)
		o_status[6] && !o_status[5] && !o_status[4] && !o_status[0])
		else $error("Fixed status bits wrong.");

endmodule : smspi_front

// File: smspi_master.sv
`timescale 1ns/1ns
module smspi_master
	import smspi_pkg::*;
(
	// Clock.
	input  wire logic i_clk,
	// Serial pins.
	input  wire logic i_so,
	input  wire logic i_so_oen,
	output logic      o_csn,
	output logic      o_sck,
	output logic      o_si,
	output logic      o_holdn
);
	logic       so_last;
	logic [7:0] rx_q [$];

	initial
	begin
		o_csn = 1'b1;
		o_sck = 1'b0;
		o_si = 1'b0;
		o_holdn = 1'b1;
		so_last = 1'b0;
	end

	// A released output line shows the inverse of its last driven level.
	always @(negedge i_clk)
		if (i_so_oen === 1'b0)
			so_last <= i_so;

	task automatic hw(input int n);
		repeat (n) @(negedge i_clk);
	endtask : hw

	task automatic frame(input logic m3, input logic [7:0] tx [$], input int hb);
		logic [7:0] r;
		rx_q = {};
		o_sck = m3;
		hw(4);
		o_csn = 1'b0;
		hw(4);
		foreach (tx[k])
		begin
			for (int b = 7; b >= 0; b--)
			begin
				if (k == 0 && b == hb)
				begin
					o_sck = 1'b0;
					hw(4);
					o_holdn = 1'b0;
					for (int t = 0; t < 6; t++)
					begin
						hw(4);
						o_sck = ~o_sck;
					end
					hw(4);
					o_holdn = 1'b1;
				end
				o_sck = 1'b0;
				o_si = tx[k][b];
				hw(4);
				o_sck = 1'b1;
				hw(2);
				r = {r[6:0], (i_so_oen === 1'b1) ? ~so_last : i_so};
				hw(2);
			end
			rx_q.push_back(r);
		end
		o_sck = m3;
		hw(4);
		o_csn = 1'b1;
		hw(8);
	endtask : frame

	task automatic noise();
		for (int t = 0; t < 8; t++)
		begin
			o_si = ~o_si;
			o_sck = ~o_sck;
			hw(4);
		end
	endtask : noise
endmodule : smspi_master

// File: smspi_front_test.sv
`timescale 1ns/1ns
module smspi_front_test
	import smspi_pkg::*;
;
	logic              i_clk, i_rst, csn, sck, si, holdn, so, so_oen, active, mode3;
	logic              cmd_valid, bad_op, addr_valid, data_valid, wstb, wl, bad_s;
	logic [3:0]        cmd, cmd_s;
	logic [ADDR_W-1:0] addr, addr_s;
	logic [7:0]        data, status, data_s, st, op, b1, b2, b3, d;
	logic [7:0]        tx [$];
	int                num_errors, n_compared, n_cmd, n_addr, n_wr, n_drv;
	logic [7:0]        ops [10] = '{8'h06, 8'h04, 8'h05, 8'h01, 8'h03,
		8'h0b, 8'h02, 8'hb9, 8'h9f, 8'hc3};

	smspi_front smspi_front_i (.i_clk(i_clk), .i_rst(i_rst), .i_csn(csn), .i_sck(sck),
		.i_si(si), .i_holdn(holdn), .o_so(so), .o_so_oen(so_oen), .o_active(active),
		.o_mode3(mode3), .o_cmd_valid(cmd_valid), .o_cmd(cmd), .o_bad_op(bad_op),
		.o_addr_valid(addr_valid), .o_addr(addr), .o_data_valid(data_valid),
		.o_data(data), .o_write_strobe(wstb), .o_write_latch(wl), .o_status(status));
	smspi_master smspi_master_i (.i_clk(i_clk), .i_so(so), .i_so_oen(so_oen),
		.o_csn(csn), .o_sck(sck), .o_si(si), .o_holdn(holdn));

	always #50 i_clk = ~i_clk;

	always @(negedge i_clk)
	begin
		n_cmd += int'(cmd_valid === 1'b1);
		n_addr += int'(addr_valid === 1'b1);
		n_wr += int'(wstb === 1'b1);
		n_drv += int'(so_oen !== 1'b1);
		bad_s |= (bad_op === 1'b1);
		if (cmd_valid === 1'b1)
			cmd_s = cmd;
		if (addr_valid === 1'b1)
			addr_s = addr;
		if (data_valid === 1'b1)
			data_s = data;
	end

	task automatic chk1(input string nm, input logic e, input logic g);
		n_compared++;
		if (g !== e)
		begin
			num_errors++;
			$display("MISMATCH %s expected %b seen %b", nm, e, g);
		end
	endtask : chk1

	task automatic chkv(input string nm, input logic [16:0] e, input logic [16:0] g);
		n_compared++;
		if (g !== e)
		begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : chkv

	function automatic logic [3:0] exp_cmd(input logic [7:0] o);
		exp_cmd = 4'h0;
		for (int i = 0; i < 10; i++)
			if (ops[i] === o)
				exp_cmd = 4'(i + 1);
	endfunction : exp_cmd

	task automatic run(input logic m3, input int hb);
		n_cmd = 0;
		n_addr = 0;
		n_wr = 0;
		n_drv = 0;
		bad_s = 1'b0;
		cmd_s = 'x;
		addr_s = 'x;
		data_s = 'x;
		smspi_master_i.frame(m3, tx, hb);
	endtask : run

	task automatic print_verdict();
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : print_verdict

	initial
	begin
		i_clk = 1'b0;
		i_rst = 1'b1;
		num_errors = 0;
		n_compared = 0;
		st = 8'h40;
		void'($urandom(27));
		repeat (2) @(negedge i_clk);
		i_rst = 1'b0;
		repeat (4) @(negedge i_clk);
		chk1("so_oen", 1'b1, so_oen);
		chk1("latch", 1'b0, wl);
		chkv("status", 17'(st), 17'(status));
		$display("test reset done");
		for (int i = 0; i < 10; i++)
		begin
			tx = {ops[i]};
			run(i[0], -1);
			chkv("n_cmd", 17'(1), 17'(n_cmd));
			chkv("cmd", 17'(exp_cmd(ops[i])), 17'(cmd_s));
			chk1("mode3", i[0], mode3);
		end
		$display("test decode done");
		tx = {8'h06};
		run(1'b0, -1);
		chk1("latch", 1'b1, wl);
		tx = {8'h05, 8'h00};
		run(1'b1, -1);
		chkv("rx", 17'(st | 8'h02), 17'(smspi_master_i.rx_q[1]));
		chk1("drove", 1'b1, n_drv > 0);
		chk1("so_oen", 1'b1, so_oen);
		$display("test status read done");
		for (int i = 0; i < 2; i++)
		begin
			d = 8'($urandom);
			tx = {8'h06};
			if (i == 0)
				run(1'b0, -1);
			tx = {8'h01, d};
			run(1'b0, -1);
			if (i == 0)
				st = 8'h40 | (d & 8'h8c);
			chkv("status", 17'(st), 17'(status));
			chk1("latch", 1'b0, wl);
		end
		$display("test status write done");
		for (int i = 0; i < 6; i++)
		begin
			op = ops[4 + i % 3];
			b1 = (i < 3) ? 8'h00 : 8'($urandom);
			b2 = 8'($urandom);
			b3 = 8'($urandom);
			d = 8'($urandom);
			tx = {8'h06};
			run(1'b0, -1);
			tx = {op, b1, b2, b3, d};
			run(i[0], -1);
			chkv("n_addr", 17'(1), 17'(n_addr));
			chkv("addr", {b1[0], b2, b3}, addr_s);
			chkv("data", 17'(d), 17'(data_s));
			chkv("n_wr", 17'(op === 8'h02), 17'(n_wr));
			chk1("latch", op !== 8'h02, wl);
		end
		$display("test address done");
		tx = {8'h06, 8'h04};
		run(1'b0, -1);
		chkv("n_cmd", 17'(1), 17'(n_cmd));
		chk1("latch", 1'b1, wl);
		tx = {8'h04};
		run(1'b1, -1);
		chk1("latch", 1'b0, wl);
		$display("test one opcode done");
		for (int i = 0; i < 4; i++)
		begin
			do op = 8'($urandom); while (exp_cmd(op) !== 4'h0);
			tx = {op, 8'h05, 8'($urandom)};
			run(i[0], -1);
			chkv("n_cmd", 17'(0), 17'(n_cmd));
			chkv("n_drv", 17'(0), 17'(n_drv));
			chk1("bad_op", 1'b1, bad_s);
		end
		$display("test invalid done");
		tx = {8'h06};
		run(1'b0, 3);
		chkv("n_cmd", 17'(1), 17'(n_cmd));
		chkv("cmd", 17'(1), 17'(cmd_s));
		$display("test hold done");
		run(1'b0, -1);
		n_cmd = 0;
		n_drv = 0;
		smspi_master_i.noise();
		repeat (8) @(negedge i_clk);
		chkv("n_cmd", 17'(0), 17'(n_cmd));
		chkv("n_drv", 17'(0), 17'(n_drv));
		$display("test deselected done");
		print_verdict();
	end
endmodule : smspi_front_test
